// ### pkg/rscr_pkg.sv
// Purpose: shared constants for the rtc status/control register bank
// Assumes: 32-bit axi4-lite, one register per aligned word, index = byte address / 4
// Notes: register indices kept as printed; byte address is four times the index
package rscr_pkg;
  // ****************************************
  // bus
  // ****************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int IDX_W = 4;
  localparam int REG_W = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] ADDR_ALIGN = 2'h0;

  // ****************************************
  // register indices
  // ****************************************
  localparam logic [IDX_W-1:0] IDX_BANK_LAST = 4'h6;
  localparam logic [IDX_W-1:0] IDX_PREC = 4'h7;
  localparam logic [IDX_W-1:0] IDX_CTL1 = 4'he;
  localparam logic [IDX_W-1:0] IDX_CTL2 = 4'hf;
  localparam int BANK_BYTES = 7;

  // ****************************************
  // status_control_two fields
  // ****************************************
  localparam int BIT_MO_ALARM = 0;
  localparam int BIT_WK_ALARM = 1;
  localparam int BIT_PERIODIC = 2;
  localparam int BIT_EVENT = 3;
  localparam int BIT_POWER_ON = 4;
  localparam int BIT_OSC_STOP = 5;
  localparam int BIT_LOW_VOLT = 6;
  localparam int BIT_BANK = 7;
  localparam int NUM_FLAGS = 7;
  // power-on and osc-stop flags read 1 after power-up
  localparam logic [NUM_FLAGS-1:0] FLAG_RESET = 7'h30;

  // ****************************************
  // control 1 fields and reset values
  // ****************************************
  localparam int CTL1_EVENT_EN = 4;
  localparam logic [REG_W-1:0] REG_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;

  function automatic logic [IDX_W-1:0] reg_index(input logic [ADDR_W-1:0] a);
    return a[IDX_W+1:2];
  endfunction : reg_index

  function automatic logic addr_legal(input logic [ADDR_W-1:0] a);
    return (a[ADDR_W-1:IDX_W+2] == '0) && (a[1:0] == ADDR_ALIGN);
  endfunction : addr_legal
endpackage : rscr_pkg

// ### src/rscr_sticky_flags.sv
// Purpose: vector of sticky flags, hardware sets, software clears
// Assumes: set and clear are single-cycle strobes sampled with ce
// Notes: a set in the clear cycle wins
`timescale 1ns/1ps
module rscr_sticky_flags
  import rscr_pkg::*;
#(
  parameter int N = NUM_FLAGS,
  parameter logic [N-1:0] RESET_VAL = '0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [N-1:0] set,
  input wire logic [N-1:0] clr,
  output logic [N-1:0] flags
);
  typedef struct packed {
    logic [N-1:0] flags;
  } rscr_flag_state_t;

  rscr_flag_state_t st_reg;
  rscr_flag_state_t st_next;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_next = st_reg;
    // set beats clear so no event is lost
    st_next.flags = set | (st_reg.flags & ~clr);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg.flags <= RESET_VAL;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign flags = st_reg.flags;
endmodule : rscr_sticky_flags

// ### src/rscr_axil_slave.sv
// Purpose: axi4-lite slave front end, one write and one read in flight
// Assumes: register side answers hit/data combinationally from the address
// Notes: address and data may arrive in either order
`timescale 1ns/1ps
module rscr_axil_slave
  import rscr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [DATA_W/8-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wr_en,
  output logic [ADDR_W-1:0] wr_addr,
  output logic [DATA_W-1:0] wr_data,
  output logic [DATA_W/8-1:0] wr_strb,
  input wire logic wr_ok,
  output logic [ADDR_W-1:0] rd_addr,
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic rd_ok
);
  typedef struct packed {
    logic aw_have;
    logic w_have;
    logic [ADDR_W-1:0] awaddr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W/8-1:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_have;
    logic [ADDR_W-1:0] araddr;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [DATA_W-1:0] rdata;
  } rscr_axi_state_t;

  rscr_axi_state_t st_reg;
  rscr_axi_state_t st_next;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_next = st_reg;
    if (s_axi_awvalid && st_reg.awready) begin
      st_next.aw_have = 1'b1;
      st_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_reg.wready) begin
      st_next.w_have = 1'b1;
      st_next.wdata = s_axi_wdata;
      st_next.wstrb = s_axi_wstrb;
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    if (wr_en) begin
      st_next.aw_have = 1'b0;
      st_next.w_have = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    // ready flops so ports come straight from registers
    st_next.awready = !st_next.aw_have && !st_next.bvalid;
    st_next.wready = !st_next.w_have && !st_next.bvalid;
    if (s_axi_arvalid && st_reg.arready) begin
      st_next.ar_have = 1'b1;
      st_next.araddr = s_axi_araddr;
    end
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (st_reg.ar_have && !st_reg.rvalid) begin
      st_next.ar_have = 1'b0;
      st_next.rvalid = 1'b1;
      st_next.rdata = rd_ok ? rd_data : WORD_ZERO;
      st_next.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    st_next.arready = !st_next.ar_have && !st_next.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
      st_reg.awready <= 1'b1;
      st_reg.wready <= 1'b1;
      st_reg.arready <= 1'b1;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign wr_en = st_reg.aw_have && st_reg.w_have && !st_reg.bvalid;
  assign wr_addr = st_reg.awaddr;
  assign wr_data = st_reg.wdata;
  assign wr_strb = st_reg.wstrb;
  assign rd_addr = st_reg.araddr;
  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready = st_reg.wready;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rresp = st_reg.rresp;
  assign s_axi_rdata = st_reg.rdata;
endmodule : rscr_axil_slave

// ### src/rscr_status_control.sv
// Purpose: rtc status/control register two with bank select and health flags
// Assumes: aresetn models the internal power-on reset; event inputs are pulses
// Notes: counters, alarm compare, debounce are outside; their events arrive as pulses
//
// Operation
// - bit 7 write selects calendar or stamp bank
// - clean capture sets stamp valid flag
// - osc stop or low voltage clears valid
// - event enable clear also clears valid
// - low voltage flag: write 0 clears
// - low voltage flag sticks at 1
// - oscillator stop sets osc stop flag
// - osc stop flag: write 0 clears
// - osc stop flag sticks, 1 at power-up
// - power-on reset sets power-on flag
// - power-on flag: write 0 clears
// - power-on flag holds control bits zero
// - power-on flag floats both interrupt outputs
// - unused bits read zero, writes ignored
// - control two defaults after power-on
// - flags at bits four, five, six
// - bank one maps 0-6 to stamps
// - event flag accepts only zero writes
// - enable clear wipes stamps and event
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module rscr_status_control
  import rscr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [DATA_W/8-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic power_on_detect,
  input wire logic backup_drop_detect,
  input wire logic osc_stop_detect,
  input wire logic stamp_event,
  input wire logic periodic_event,
  input wire logic weekday_alarm_event,
  input wire logic hourmin_alarm_event,
  input wire logic [BANK_BYTES*REG_W-1:0] calendar_time,
  output logic bank_select,
  output logic event_detect_enable,
  output logic [REG_W-1:0] control_one,
  output logic [REG_W-1:0] precision_adjust,
  output logic cal_wr_en,
  output logic [IDX_W-1:0] cal_wr_idx,
  output logic [REG_W-1:0] cal_wr_data,
  output logic irq_out_a_o,
  output logic irq_out_a_oe,
  output logic irq_out_b_o,
  output logic irq_out_b_oe
);
  typedef struct packed {
    logic bank;
    logic stamp_valid_flag;
    logic [REG_W-1:0] ctl1;
    logic [REG_W-1:0] prec;
    logic [BANK_BYTES-1:0][REG_W-1:0] stamp;
    logic cal_wr_en;
    logic [IDX_W-1:0] cal_wr_idx;
    logic [REG_W-1:0] cal_wr_data;
    logic irq_a_oe;
    logic irq_b_oe;
  } rscr_state_t;

  rscr_state_t st_reg;
  rscr_state_t st_next;

  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [DATA_W/8-1:0] wr_strb;
  logic wr_ok;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  logic rd_ok;
  logic [NUM_FLAGS-1:0] flag_set;
  logic [NUM_FLAGS-1:0] flag_clr;
  logic [NUM_FLAGS-1:0] flags;
  logic [IDX_W-1:0] wr_idx;
  logic [IDX_W-1:0] rd_idx;
  logic byte0_wr;
  logic ctl2_wr;
  logic power_on_flag;
  logic capture;
  logic enable_off;
  logic [BANK_BYTES-1:0][REG_W-1:0] cal_bytes;

  // ****************************************
  // bus front end
  // ****************************************
  rscr_axil_slave u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  // ****************************************
  // decode
  // ****************************************
  assign wr_idx = reg_index(wr_addr);
  assign rd_idx = reg_index(rd_addr);
  assign cal_bytes = calendar_time;
  // registers hold 8 bits; only lane 0 carries a write
  assign byte0_wr = wr_en && wr_strb[0];
  // control two decoded regardless of bank
  assign ctl2_wr = byte0_wr && addr_legal(wr_addr) && (wr_idx == IDX_CTL2);
  assign power_on_flag = flags[BIT_POWER_ON];

  always_comb begin
    wr_ok = 1'b0;
    if (addr_legal(wr_addr)) begin
      wr_ok = (wr_idx <= IDX_BANK_LAST) || (wr_idx == IDX_PREC) ||
              (wr_idx == IDX_CTL1) || (wr_idx == IDX_CTL2);
    end
  end

  // ****************************************
  // read mux
  // ****************************************
  always_comb begin
    rd_data = WORD_ZERO;
    rd_ok = addr_legal(rd_addr);
    if (rd_ok) begin
      // upper bits and unmapped words read zero
      if (rd_idx <= IDX_BANK_LAST) begin
        // bank one shows stamps in place of calendar
        if (st_reg.bank) begin
          rd_data[REG_W-1:0] = st_reg.stamp[rd_idx];
        end else begin
          rd_data[REG_W-1:0] = cal_bytes[rd_idx];
        end
      end else if (rd_idx == IDX_PREC) begin
        rd_data[REG_W-1:0] = st_reg.prec;
      end else if (rd_idx == IDX_CTL1) begin
        rd_data[REG_W-1:0] = st_reg.ctl1;
      end else if (rd_idx == IDX_CTL2) begin
        rd_data[REG_W-1:0] = {st_reg.stamp_valid_flag, flags};
      end else begin
        rd_ok = 1'b0;
      end
    end
  end

  // ****************************************
  // sticky flags
  // ****************************************
  assign enable_off = !st_reg.ctl1[CTL1_EVENT_EN];
  // first event only; later ones wait for a flag clear
  assign capture = stamp_event && !enable_off && !flags[BIT_EVENT] && !power_on_flag;

  always_comb begin
    flag_set = '0;
    flag_clr = '0;
    flag_set[BIT_OSC_STOP] = osc_stop_detect;
    flag_set[BIT_LOW_VOLT] = backup_drop_detect;
    flag_set[BIT_POWER_ON] = power_on_detect;
    flag_set[BIT_EVENT] = capture;
    flag_set[BIT_PERIODIC] = periodic_event && !power_on_flag;
    flag_set[BIT_WK_ALARM] = weekday_alarm_event && !power_on_flag;
    flag_set[BIT_MO_ALARM] = hourmin_alarm_event && !power_on_flag;
    if (ctl2_wr) begin
      flag_clr = ~wr_data[NUM_FLAGS-1:0];
    end
    if (enable_off) begin
      flag_clr[BIT_EVENT] = 1'b1;
    end
    if (power_on_flag) begin
      flag_clr[BIT_EVENT] = 1'b1;
      flag_clr[BIT_PERIODIC] = 1'b1;
      flag_clr[BIT_WK_ALARM] = 1'b1;
      flag_clr[BIT_MO_ALARM] = 1'b1;
    end
  end

  // osc stop and power-on start at 1
  rscr_sticky_flags #(
    .N(NUM_FLAGS),
    .RESET_VAL(FLAG_RESET)
  ) u_flags (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .set(flag_set),
    .clr(flag_clr),
    .flags(flags)
  );

  // ****************************************
  // control state
  // ****************************************
  always_comb begin
    st_next = st_reg;
    st_next.cal_wr_en = 1'b0;
    if (byte0_wr && wr_ok) begin
      if (wr_idx == IDX_CTL2) begin
        st_next.bank = wr_data[BIT_BANK];
      end else if (wr_idx == IDX_CTL1) begin
        st_next.ctl1 = wr_data[REG_W-1:0];
      end else if (wr_idx == IDX_PREC) begin
        st_next.prec = wr_data[REG_W-1:0];
      end else if (!st_reg.bank) begin
        // calendar writes pass to the counters; stamp bank is read-only
        st_next.cal_wr_en = 1'b1;
        st_next.cal_wr_idx = wr_idx;
        st_next.cal_wr_data = wr_data[REG_W-1:0];
      end
    end
    if (capture) begin
      st_next.stamp = cal_bytes;
    end
    // unreliable clock or supply voids stamp
    if (flags[BIT_OSC_STOP] || flags[BIT_LOW_VOLT]) begin
      st_next.stamp_valid_flag = 1'b0;
    end
    if (enable_off) begin
      st_next.stamp_valid_flag = 1'b0;
    end
    if (enable_off) begin
      st_next.stamp = '0;
    end
    if (capture && !flags[BIT_OSC_STOP] && !flags[BIT_LOW_VOLT]) begin
      st_next.stamp_valid_flag = 1'b1;
    end
    if (power_on_flag) begin
      st_next.bank = 1'b0;
      st_next.stamp_valid_flag = 1'b0;
      st_next.ctl1 = REG_ZERO;
      st_next.prec = REG_ZERO;
      st_next.stamp = '0;
    end
    // float both pins while power-on flag set
    st_next.irq_a_oe = !flags[BIT_POWER_ON] &&
                       (flags[BIT_EVENT] || flags[BIT_MO_ALARM]);
    st_next.irq_b_oe = !flags[BIT_POWER_ON] &&
                       (flags[BIT_WK_ALARM] || flags[BIT_PERIODIC]);
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // bank and valid default to zero
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign bank_select = st_reg.bank;
  assign event_detect_enable = st_reg.ctl1[CTL1_EVENT_EN];
  assign control_one = st_reg.ctl1;
  assign precision_adjust = st_reg.prec;
  assign cal_wr_en = st_reg.cal_wr_en;
  assign cal_wr_idx = st_reg.cal_wr_idx;
  assign cal_wr_data = st_reg.cal_wr_data;
  // open drain: only ever pulls low
  assign irq_out_a_o = 1'b0;
  assign irq_out_b_o = 1'b0;
  assign irq_out_a_oe = st_reg.irq_a_oe;
  assign irq_out_b_oe = st_reg.irq_b_oe;
endmodule : rscr_status_control

// ### verification/rscr_status_control_asserts.sv
// Purpose: port-level checks of the status/control register bank
// Assumes: ce held high, write address and data offered together
// Notes: sees only the top module's ports
`timescale 1ns/1ps
module rscr_status_control_asserts
  import rscr_pkg::*;
(
  input logic aclk,
  input logic aresetn,
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [ADDR_W-1:0] s_axi_araddr,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic [DATA_W-1:0] s_axi_rdata,
  input logic [1:0] s_axi_rresp,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic power_on_detect,
  input logic bank_select,
  input logic [REG_W-1:0] control_one,
  input logic [REG_W-1:0] precision_adjust,
  input logic cal_wr_en,
  input logic [IDX_W-1:0] cal_wr_idx,
  input logic irq_out_a_oe,
  input logic irq_out_b_oe
);
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_wr_lat;
    s_wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
  property p_rd_lat;
    s_rd_take |=> !s_axi_rvalid ##1 s_axi_rvalid;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_upper_zero;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("unused bits set");
  property p_slverr;
    s_axi_arvalid && s_axi_arready && s_axi_araddr[7:6] != 2'h0
      |=> ##1 s_axi_rresp == RESP_SLVERR && s_axi_rdata == WORD_ZERO;
  endproperty
  a_slverr: assert property (p_slverr) else $error("unmapped read accepted");
  property p_cal_bank;
    cal_wr_en |-> !bank_select && cal_wr_idx <= IDX_BANK_LAST;
  endproperty
  a_cal_bank: assert property (p_cal_bank) else $error("stamp bank written");
  property p_pon_hold;
    power_on_detect |=> ##1 control_one == REG_ZERO && precision_adjust == REG_ZERO && !bank_select;
  endproperty
  a_pon_hold: assert property (p_pon_hold) else $error("control bits kept");
  property p_pon_float;
    power_on_detect |=> ##1 !(irq_out_a_oe || irq_out_b_oe);
  endproperty
  a_pon_float: assert property (p_pon_float) else $error("irq driven at power-on");
endmodule : rscr_status_control_asserts

bind rscr_status_control rscr_status_control_asserts rscr_status_control_asserts_i (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .power_on_detect, .bank_select, .control_one,
  .precision_adjust, .cal_wr_en, .cal_wr_idx, .irq_out_a_oe, .irq_out_b_oe
);

// ### verification/rscr_host_model.sv
// Purpose: host side axi4-lite master for the register bank
// Assumes: one write or one read at a time
// Notes: released address and data lines show the inverse, never the old value
`timescale 1ns/1ps
module rscr_host_model
  import rscr_pkg::*;
(
  input logic aclk,
  output logic [ADDR_W-1:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input logic s_axi_awready,
  output logic [DATA_W-1:0] s_axi_wdata,
  output logic [DATA_W/8-1:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic s_axi_rvalid,
  output logic s_axi_rready
);
  // ****************************************
  // bus cycles
  // ****************************************
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
  end
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic aw = 1'b0, w = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : rscr_host_model

// ### verification/rscr_status_control_tb.sv
// Purpose: self-checking bench of the status/control register bank
// Assumes: ce low only while the bus is idle, events are one-cycle pulses
// Notes: expected reads queued by the driver, compared by the monitor
`timescale 1ns/1ps
module rscr_status_control_tb;
  import rscr_pkg::*;
  localparam logic [7:0] A_CTL1 = 8'h38;
  localparam logic [7:0] A_CTL2 = 8'h3c;
  logic aclk = 1'b0;
  logic aresetn = 1'b0, ce = 1'b1;
  logic [6:0] ev = 7'h00;
  logic [55:0] cal = '0;
  logic [55:0] saved;
  logic [15:0] rnd = 16'h0d5d;
  logic [11:0] cw = '0;
  int cw_n = 0, cyc = 0;
  int failures = 0;
  int checked = 0;
  logic [33:0] eq_r[$];
  logic [1:0] eq_b[$];
  wire [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  wire [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
  wire [3:0] s_axi_wstrb;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, bank_select, event_detect_enable;
  wire [REG_W-1:0] control_one, precision_adjust, cal_wr_data;
  wire [IDX_W-1:0] cal_wr_idx;
  wire cal_wr_en, irq_out_a_oe, irq_out_b_oe;
  always #20 aclk = ~aclk;
  rscr_status_control rscr_status_control_i (
    .aclk, .aresetn, .ce(ce), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .power_on_detect(ev[0]), .backup_drop_detect(ev[1]), .osc_stop_detect(ev[2]),
    .stamp_event(ev[3]), .periodic_event(ev[4]), .weekday_alarm_event(ev[5]),
    .hourmin_alarm_event(ev[6]), .calendar_time(cal), .bank_select, .event_detect_enable,
    .control_one, .precision_adjust, .cal_wr_en, .cal_wr_idx, .cal_wr_data, .irq_out_a_o(),
    .irq_out_a_oe, .irq_out_b_o(), .irq_out_b_oe
  );
  rscr_host_model rscr_host_model_i (
    .aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready
  );
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic check(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic end_of_test;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test
  task automatic rchk(input logic [7:0] a, input logic [7:0] e, input logic [1:0] r = RESP_OKAY);
    eq_r.push_back({r, 24'h0, e});
    rscr_host_model_i.rd(a);
  endtask : rchk
  task automatic wchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    eq_b.push_back(r);
    rscr_host_model_i.wr(a, d);
  endtask : wchk
  task automatic pulse(input logic [6:0] m);
    @(posedge aclk);
    ev <= m;
    @(posedge aclk);
    ev <= 7'h00;
  endtask : pulse
  // new calendar bytes land at an edge, so capture never races them
  task automatic rand_cal;
    for (int i = 0; i < 7; i++) begin
      rnd = lfsr(rnd);
      cal[8*i +: 8] <= rnd[7:0];
    end
  endtask : rand_cal
  // ****************************************
  // monitor and timeout
  // ****************************************
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) check("read", {s_axi_rresp, s_axi_rdata}, eq_r.pop_front());
    if (s_axi_bvalid && s_axi_bready) check("bresp", 34'(s_axi_bresp), 34'(eq_b.pop_front()));
    if (cal_wr_en) begin
      cw = {cal_wr_idx, cal_wr_data};
      cw_n++;
    end
    cyc++;
    if (cyc == 5000) begin
      failures++;
      end_of_test;
    end
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(A_CTL2, 8'h30);
    rchk(A_CTL1, 8'h00);
    $display("test reset done");
    wchk(A_CTL1, 32'h10);
    wchk(8'h1c, 32'h7f);
    wchk(A_CTL2, 32'hb0);
    pulse(7'h70);
    rchk(A_CTL1, 8'h00);
    rchk(8'h1c, 8'h00);
    rchk(A_CTL2, 8'h30);
    check("oe", 34'({irq_out_a_oe, irq_out_b_oe, bank_select}), 34'h0);
    $display("test power-on hold done");
    wchk(A_CTL2, 32'h7f);
    rchk(A_CTL2, 8'h30);
    wchk(A_CTL2, 32'hffff_ff00);
    rchk(A_CTL2, 8'h00);
    $display("test clear done");
    pulse(7'h06);
    rchk(A_CTL2, 8'h60);
    rchk(A_CTL2, 8'h60);
    rnd = lfsr(rnd);
    wchk(8'h00, {24'h0, rnd[7:0]});
    check("calwr", 34'(cw), 34'({4'h0, rnd[7:0]}));
    wchk(A_CTL2, 32'h5f);
    rchk(A_CTL2, 8'h40);
    wchk(A_CTL2, 32'h00);
    ce <= 1'b0;
    pulse(7'h06);
    ce <= 1'b1;
    rchk(A_CTL2, 8'h00);
    pulse(7'h70);
    rchk(A_CTL2, 8'h07);
    check("oe on", 34'({irq_out_a_oe, irq_out_b_oe}), 34'h3);
    wchk(A_CTL2, 32'h00);
    rchk(A_CTL2, 8'h00);
    $display("test flags done");
    rand_cal;
    wchk(A_CTL1, 32'h10);
    rchk(A_CTL1, 8'h10);
    pulse(7'h08);
    saved = cal;
    rand_cal;
    rchk(A_CTL2, 8'h88);
    wchk(A_CTL2, 32'h88);
    check("bank", 34'({bank_select, event_detect_enable}), 34'h3);
    for (int i = 0; i < 7; i++) rchk(8'(4 * i), saved[8*i +: 8]);
    wchk(8'h00, 32'h55);
    check("cal count", 34'(cw_n), 34'h1);
    rchk(8'h00, saved[7:0]);
    rchk(A_CTL2, 8'h88);
    wchk(A_CTL2, 32'hf7);
    rchk(A_CTL2, 8'h80);
    wchk(A_CTL2, 32'h08);
    rchk(8'h00, cal[7:0]);
    pulse(7'h04);
    rchk(A_CTL2, 8'h20);
    wchk(A_CTL1, 32'h00);
    wchk(A_CTL2, 32'h80);
    rchk(8'h00, 8'h00);
    rchk(A_CTL2, 8'h00);
    wchk(A_CTL2, 32'h00);
    $display("test stamp done");
    rchk(8'h20, 8'h00, RESP_SLVERR);
    rchk(8'h40, 8'h00, RESP_SLVERR);
    wchk(8'h3d, 32'h0, RESP_SLVERR);
    wchk(8'h34, 32'h0, RESP_SLVERR);
    $display("test refuse done");
    wchk(A_CTL1, 32'h10);
    pulse(7'h01);
    rchk(A_CTL1, 8'h00);
    $display("test power-on again done");
    @(posedge aclk);
    end_of_test;
  end
endmodule : rscr_status_control_tb
